// ---- design/tx_and_hw_config_regs.sv ----
/*
 * transmit configuration and hardware configuration registers with
 * stop/halt handshake, fifo flush pulses, fifo memory split, strap
 * readback, soft reset with timeout and receive end padding count.
 * assumes a synchronous host port and mac status inputs on clk.
 */
`timescale 1ns/1ps
module tx_and_hw_config_regs (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [eth_cfg_pkg::ADDR_W-1:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	input wire logic wake_event,
	input wire logic crossover_auto_strap,
	input wire logic bus_width_strap,
	input wire logic phy_clocks_running,
	input wire logic tx_busy,
	input wire logic tx_status_full,
	input wire logic [1:0] rx_end_align_code,
	input wire logic [11:0] rx_buffer_dwords,
	output logic tx_status_flush,
	output logic tx_data_flush,
	output logic tx_send,
	output logic status_full_irq,
	output logic mac_soft_reset,
	output logic [14:0] tx_data_bytes,
	output logic [14:0] rx_data_bytes,
	output logic [14:0] rx_status_bytes,
	output logic [2:0] rx_pad_dwords
);
	import eth_cfg_pkg::*;

	typedef struct packed {
		sr_state_type sr;
		logic [8:0] sr_cnt;
		logic armed;
		logic strap_taken;
		logic crossover;
		logic bus_width;
		logic stop;
		logic tx_on;
		logic allow;
		logic must_one;
		logic [3:0] alloc;
		logic timeout;
		logic status_flush;
		logic data_flush;
		logic tx_send;
		logic status_full_irq;
		logic mac_soft_reset;
		logic [31:0] rdata;
		logic [44:0] split;
		logic [2:0] rx_pad;
	} state_type;

	localparam logic [8:0] SR_LAST =
		9'(SOFT_RESET_TIMEOUT_CYCLES - 1);

	// tx data, rx data, rx status byte counts
	function automatic logic [44:0] fifo_split(input logic [3:0] a);
		logic [14:0] tx_total;
		logic [14:0] rx_total;
		logic [14:0] rx_stat;
		tx_total = {1'b0, a, 10'h000};
		rx_total = FIFO_TOTAL_BYTES - tx_total;
		rx_stat = rx_total >> RX_STATUS_SHIFT;
		return {tx_total - TX_STATUS_BYTES,
			rx_total - rx_stat, rx_stat};
	endfunction : fifo_split

	localparam state_type RESET_STATE = '{
		sr: SR_IDLE,
		alloc: ALLOC_RESET,
		split: fifo_split(ALLOC_RESET),
		default: '0
	};

	state_type st_r;
	state_type st_nxt;
	logic wr_ok;
	logic wr_tx;
	logic wr_hw;
	logic [2:0] align_mask;

	always_comb begin
		st_nxt = st_r;
		wr_ok = host_wr && st_r.armed;
		wr_tx = wr_ok && host_addr == TX_CONFIG_OFFSET;
		wr_hw = wr_ok && host_addr == HW_CONFIG_OFFSET;
		st_nxt.status_flush = 1'b0;
		st_nxt.data_flush = 1'b0;
		st_nxt.mac_soft_reset = 1'b0;
		align_mask = 3'h0;

		// straps caught once, first cycle after reset
		if (!st_r.strap_taken) begin
			st_nxt.strap_taken = 1'b1;
			st_nxt.crossover = crossover_auto_strap;
			st_nxt.bus_width = bus_width_strap;
		end

		// first read arms writes, wake disarms
		if (host_rd) begin
			st_nxt.armed = 1'b1;
		end else if (wake_event) begin
			st_nxt.armed = 1'b0;
		end

		// register reads, reserved bits zero
		if (host_rd) begin
			st_nxt.rdata = 32'h0000_0000;
			if (host_addr == TX_CONFIG_OFFSET) begin
				st_nxt.rdata[TXC_OVERRUN_ALLOW_BIT] = st_r.allow;
				st_nxt.rdata[TXC_ENABLE_BIT] = st_r.tx_on;
				st_nxt.rdata[TXC_STOP_BIT] = st_r.stop;
			end else if (host_addr == HW_CONFIG_OFFSET) begin
				st_nxt.rdata[HWC_CROSSOVER_BIT] = st_r.crossover;
				st_nxt.rdata[HWC_MUST_BE_ONE_BIT] = st_r.must_one;
				st_nxt.rdata[HWC_ALLOC_MSB:HWC_ALLOC_LSB] = st_r.alloc;
				st_nxt.rdata[HWC_BUS_WIDTH_BIT] = st_r.bus_width;
				st_nxt.rdata[HWC_TIMEOUT_BIT] = st_r.timeout;
				st_nxt.rdata[HWC_SOFT_RESET_BIT] = st_r.sr == SR_WAIT;
			end
		end

		// transmit configuration writes
		if (wr_tx) begin
			st_nxt.status_flush =
				host_wdata[TXC_STATUS_FLUSH_BIT];
			st_nxt.data_flush =
				host_wdata[TXC_DATA_FLUSH_BIT];
			st_nxt.allow = host_wdata[TXC_OVERRUN_ALLOW_BIT];
			st_nxt.tx_on = host_wdata[TXC_ENABLE_BIT];
			if (!st_r.stop) begin
				st_nxt.stop = host_wdata[TXC_STOP_BIT];
			end
		end

		// hardware configuration writes
		if (wr_hw) begin
			st_nxt.must_one = host_wdata[HWC_MUST_BE_ONE_BIT];
			if (host_wdata[HWC_ALLOC_MSB:HWC_ALLOC_LSB] >= ALLOC_MIN &&
				host_wdata[HWC_ALLOC_MSB:HWC_ALLOC_LSB] <= ALLOC_MAX) begin
				st_nxt.alloc =
					host_wdata[HWC_ALLOC_MSB:HWC_ALLOC_LSB];
			end
			if (host_wdata[HWC_SOFT_RESET_BIT] && st_r.sr == SR_IDLE) begin
				st_nxt.sr = SR_WAIT;
				st_nxt.sr_cnt = 9'h000;
				st_nxt.timeout = 1'b0;
			end
		end

		// halt completes once current frame is done
		if (st_r.stop && !tx_busy) begin
			st_nxt.stop = 1'b0;
			st_nxt.tx_on = 1'b0;
		end

		// soft reset sequencing
		case (st_r.sr)
			SR_IDLE: begin
				st_nxt.sr_cnt = st_nxt.sr_cnt;
			end
			SR_WAIT: begin
				if (phy_clocks_running) begin
					st_nxt.sr = SR_IDLE;
					st_nxt.mac_soft_reset = 1'b1;
					st_nxt.stop = 1'b0;
					st_nxt.tx_on = 1'b0;
					st_nxt.allow = 1'b0;
				end else if (st_r.sr_cnt == SR_LAST) begin
					st_nxt.sr = SR_IDLE;
					st_nxt.timeout = 1'b1;
				end else begin
					st_nxt.sr_cnt = st_r.sr_cnt + 9'h001;
				end
			end
			default: begin
				st_nxt.sr = SR_IDLE;
			end
		endcase

		// sending gate
		st_nxt.tx_send = st_r.tx_on && !st_r.stop &&
			!(tx_status_full && !st_r.allow);
		st_nxt.status_full_irq = tx_status_full;

		st_nxt.split = fifo_split(st_r.alloc);

		// receive end padding
		case (rx_end_align_code)
			ALIGN_4: align_mask = 3'h0;
			ALIGN_16: align_mask = ALIGN_16_MASK;
			ALIGN_32: align_mask = ALIGN_32_MASK;
			default: align_mask = 3'h0;
		endcase
		st_nxt.rx_pad = 3'(3'h0 - rx_buffer_dwords[2:0]) &
			align_mask;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= RESET_STATE;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign host_rdata = st_r.rdata;
	assign tx_status_flush = st_r.status_flush;
	assign tx_data_flush = st_r.data_flush;
	assign tx_send = st_r.tx_send;
	assign status_full_irq = st_r.status_full_irq;
	assign mac_soft_reset = st_r.mac_soft_reset;
	assign tx_data_bytes = st_r.split[44:30];
	assign rx_data_bytes = st_r.split[29:15];
	assign rx_status_bytes = st_r.split[14:0];
	assign rx_pad_dwords = st_r.rx_pad;

	// checks
	sequence tx_write_s;
		clk_en && st_r.armed && host_wr && host_addr == TX_CONFIG_OFFSET;
	endsequence

	sequence halt_ready_s;
		clk_en && st_r.stop && !tx_busy;
	endsequence

	sequence timeout_last_s;
		clk_en && st_r.sr == SR_WAIT && !phy_clocks_running &&
			st_r.sr_cnt == SR_LAST;
	endsequence

	sequence reset_done_s;
		clk_en && st_r.sr == SR_WAIT && phy_clocks_running;
	endsequence

	status_flush_a: assert property (
		@(posedge clk) disable iff (reset)
		tx_write_s ##0 host_wdata[TXC_STATUS_FLUSH_BIT] |=> tx_status_flush)
		else $error("status flush pulse missing");

	data_flush_a: assert property (
		@(posedge clk) disable iff (reset)
		tx_write_s ##0 !host_wdata[TXC_DATA_FLUSH_BIT] |=> !tx_data_flush)
		else $error("data flush without request");

	data_flush_set_a: assert property (
		@(posedge clk) disable iff (reset)
		tx_write_s ##0 host_wdata[TXC_DATA_FLUSH_BIT] |=> tx_data_flush)
		else $error("data flush pulse missing");

	stop_ignore_a: assert property (
		@(posedge clk) disable iff (reset)
		tx_write_s ##0 (st_r.stop && tx_busy && st_r.sr == SR_IDLE) |=>
		st_r.stop)
		else $error("stop bit changed by write while high");

	halt_clear_a: assert property (
		@(posedge clk) disable iff (reset)
		halt_ready_s |=> !st_r.stop && !st_r.tx_on)
		else $error("halt did not clear stop and enable");

	send_suspend_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && tx_status_full && !st_r.allow |=> !tx_send)
		else $error("sending with full status fifo");

	tx_send_on_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && st_r.tx_on && !st_r.stop && !tx_status_full |=> tx_send)
		else $error("enabled transmitter not sending");

	irq_independent_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en |=> status_full_irq == $past(tx_status_full))
		else $error("status full interrupt differs from fifo state");

	strap_read_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && host_rd && host_addr == HW_CONFIG_OFFSET |=>
		host_rdata[HWC_CROSSOVER_BIT] == $past(st_r.crossover) &&
		host_rdata[HWC_BUS_WIDTH_BIT] == $past(st_r.bus_width))
		else $error("strap readback wrong");

	strap_capture_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && !st_r.strap_taken |=>
		st_r.crossover == $past(crossover_auto_strap) &&
		st_r.bus_width == $past(bus_width_strap))
		else $error("strap levels not captured");

	write_lock_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && !st_r.armed && host_wr && st_r.sr == SR_IDLE |=>
		$stable(st_r.allow) && $stable(st_r.alloc))
		else $error("write accepted before first read");

	reset_timeout_a: assert property (
		@(posedge clk) disable iff (reset)
		timeout_last_s |=> st_r.timeout && st_r.sr == SR_IDLE &&
		!mac_soft_reset)
		else $error("soft reset timeout not flagged");

	soft_reset_done_a: assert property (
		@(posedge clk) disable iff (reset)
		reset_done_s |=> mac_soft_reset && !st_r.tx_on && !st_r.stop &&
		st_r.sr == SR_IDLE)
		else $error("soft reset did not complete");

	fifo_total_a: assert property (
		@(posedge clk) disable iff (reset)
		16'(tx_data_bytes) + 16'(TX_STATUS_BYTES) + 16'(rx_data_bytes) +
		16'(rx_status_bytes) == 16'(FIFO_TOTAL_BYTES))
		else $error("fifo split does not fill memory");

	align_pad_a: assert property (
		@(posedge clk) disable iff (reset)
		clk_en && rx_end_align_code == ALIGN_32 |=>
		3'(rx_pad_dwords + $past(rx_buffer_dwords[2:0])) == 3'h0)
		else $error("receive padding misses alignment");
endmodule : tx_and_hw_config_regs

// ---- design/eth_cfg_pkg.sv ----
/*
 * constants for the transmit and hardware configuration register pair:
 * offsets, bit positions, reset values, fifo split figures, timing counts.
 * assumes a 25 MHz device clock.
 */
package eth_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] TX_CONFIG_OFFSET = 8'h70;
	localparam logic [7:0] HW_CONFIG_OFFSET = 8'h74;
	localparam int TXC_STATUS_FLUSH_BIT = 15;
	localparam int TXC_DATA_FLUSH_BIT = 14;
	localparam int TXC_OVERRUN_ALLOW_BIT = 2;
	localparam int TXC_ENABLE_BIT = 1;
	localparam int TXC_STOP_BIT = 0;
	localparam int HWC_CROSSOVER_BIT = 24;
	localparam int HWC_MUST_BE_ONE_BIT = 20;
	localparam int HWC_ALLOC_LSB = 16;
	localparam int HWC_ALLOC_MSB = 19;
	localparam int HWC_BUS_WIDTH_BIT = 2;
	localparam int HWC_TIMEOUT_BIT = 1;
	localparam int HWC_SOFT_RESET_BIT = 0;
	localparam logic [3:0] ALLOC_RESET = 4'h5;
	localparam logic [3:0] ALLOC_MIN = 4'h2;
	localparam logic [3:0] ALLOC_MAX = 4'hE;
	localparam logic [14:0] FIFO_TOTAL_BYTES = 15'h4000;
	localparam logic [14:0] TX_STATUS_BYTES = 15'h0200;
	localparam int RX_STATUS_SHIFT = 4;
	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [2:0] ALIGN_16_MASK = 3'h3;
	localparam logic [2:0] ALIGN_32_MASK = 3'h7;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SOFT_RESET_TIMEOUT_NS = 10000;
	localparam int SOFT_RESET_TIMEOUT_CYCLES =
		SOFT_RESET_TIMEOUT_NS / CLK_PERIOD_NS;
	typedef enum logic {
		SR_IDLE = 1'b0,
		SR_WAIT = 1'b1
	} sr_state_type;
endpackage : eth_cfg_pkg

// ---- verification/host_model.sv ----
/*
 * host processor model: single-cycle reads and writes on the register port.
 * assumes a rising-edge synchronous port with one-cycle read latency.
 */
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic [31:0] host_rdata,
	output logic [7:0] host_addr,
	output logic host_rd,
	output logic host_wr,
	output logic [31:0] host_wdata
);
	initial begin
		host_addr = 8'h00;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_wdata = 32'h00000000;
	end
	// read data taken at the edge that accepts the request
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		#1 v = host_rdata;
	endtask : rd32
	// released data lines show the inverse of the last word
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		host_addr <= a;
		host_wr <= 1'b1;
		host_wdata <= v;
		@(posedge clk);
		host_wr <= 1'b0;
		host_wdata <= ~v;
	endtask : wr32
endmodule : host_model

// ---- verification/tx_and_hw_config_regs_bench.sv ----
/*
 * bench for the config register pair: random and corner stimulus.
 * assumes the host model is the only master of the register port.
 */
`timescale 1ns/1ps
module tx_and_hw_config_regs_bench;
	import eth_cfg_pkg::*;
	logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, wake_event = 1'b0;
	logic crossover_auto_strap = 1'b1, bus_width_strap = 1'b0;
	logic phy_clocks_running = 1'b0, tx_busy = 1'b0, tx_status_full = 1'b0;
	logic [1:0] rx_end_align_code = 2'h0;
	logic [11:0] rx_buffer_dwords = 12'h000;
	logic [7:0] host_addr;
	logic host_rd, host_wr, tx_status_flush, tx_data_flush, tx_send;
	logic status_full_irq, mac_soft_reset;
	logic [31:0] host_wdata, host_rdata, d;
	logic [14:0] tx_data_bytes, rx_data_bytes, rx_status_bytes;
	logic [2:0] rx_pad_dwords;
	logic [3:0] a, cur;
	int seed = 32'h8397;
	int err_total = 0;
	int check_count = 0;
	int n;
	always #20 clk = ~clk;
	tx_and_hw_config_regs DUT (.clk, .reset, .clk_en, .host_addr, .host_rd,
		.host_wr, .host_wdata, .host_rdata, .wake_event, .crossover_auto_strap,
		.bus_width_strap, .phy_clocks_running, .tx_busy, .tx_status_full,
		.rx_end_align_code, .rx_buffer_dwords, .tx_status_flush, .tx_data_flush,
		.tx_send, .status_full_irq, .mac_soft_reset, .tx_data_bytes,
		.rx_data_bytes, .rx_status_bytes, .rx_pad_dwords);
	host_model h (.clk, .host_rdata, .host_addr, .host_rd, .host_wr,
		.host_wdata);
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	function automatic logic [31:0] hwf(input logic m, input logic [3:0] f,
		input logic [1:0] s);
		hwf = {7'h00, crossover_auto_strap, 3'h0, m, f, 13'h0000,
			bus_width_strap, s};
	endfunction : hwf
	function automatic logic [2:0] padf(input logic [1:0] c,
		input logic [11:0] w);
		padf = (c == 2'h1) ? 3'(-w) & 3'h3 : (c == 2'h2) ? 3'(-w) : 3'h0;
	endfunction : padf
	task automatic sizes(input logic [3:0] f);
		int t;
		t = f * 1024;
		chk("tx_data_bytes", t - 512, tx_data_bytes);
		chk("rx_status_bytes", (16384 - t) / 16, rx_status_bytes);
		chk("rx_data_bytes", (16384 - t) * 15 / 16, rx_data_bytes);
	endtask : sizes
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		h.wr32(TX_CONFIG_OFFSET, 32'h00000002);
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("tx config unarmed", 32'h0, d);
		h.rd32(HW_CONFIG_OFFSET, d);
		chk("hw config reset", hwf(1'b0, 4'h5, 2'h0), d);
		sizes(4'h5);
		cur = 4'h5;
		for (int i = 0; i < 10; i++) begin
			a = (i < 4) ? 16'hE21F >> (i * 4) : $random(seed);
			d = $random(seed);
			d = {d[31:21], 1'b1, a, d[15:1], 1'b0};
			h.wr32(HW_CONFIG_OFFSET, d);
			if (a >= ALLOC_MIN && a <= ALLOC_MAX) cur = a;
			h.rd32(HW_CONFIG_OFFSET, d);
			chk("hw config word", hwf(1'b1, cur, 2'h0), d);
			sizes(cur);
		end
		tx_status_full <= 1'b1;
		h.wr32(TX_CONFIG_OFFSET, 32'hFFFFC006);
		#1 chk("flush pulses", 2'h3,
			{tx_status_flush, tx_data_flush});
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("tx config word", 32'h6, d);
		chk("send allowed full", 1'b1, tx_send);
		h.wr32(TX_CONFIG_OFFSET, 32'h00000002);
		repeat (2) @(posedge clk);
		#1 chk("send held full", 2'h1,
			{tx_send, status_full_irq});
		tx_status_full <= 1'b0;
		tx_busy <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("send queued", 1'b1, tx_send);
		h.wr32(TX_CONFIG_OFFSET, 32'h00000003);
		h.wr32(TX_CONFIG_OFFSET, 32'h00000002);
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("stop held busy", 32'h3, d);
		chk("send stopped", 1'b0, tx_send);
		tx_busy <= 1'b0;
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("halt clears", 32'h0, d);
		for (int i = 0; i < 12; i++) begin
			rx_end_align_code <= (i < 4) ? 2'(i) : 2'($random(seed));
			rx_buffer_dwords <= $random(seed);
			repeat (2) @(posedge clk);
			#1 chk("rx pad", padf(rx_end_align_code, rx_buffer_dwords),
				rx_pad_dwords);
		end
		h.wr32(TX_CONFIG_OFFSET, 32'h00000004);
		h.wr32(HW_CONFIG_OFFSET, hwf(1'b1, cur, 2'h1));
		h.rd32(HW_CONFIG_OFFSET, d);
		chk("reset pending", hwf(1'b1, cur, 2'h1), d);
		repeat (260) @(posedge clk);
		h.rd32(HW_CONFIG_OFFSET, d);
		chk("reset timeout", hwf(1'b1, cur, 2'h2), d);
		phy_clocks_running <= 1'b1;
		h.wr32(HW_CONFIG_OFFSET, hwf(1'b1, cur, 2'h1));
		n = 0;
		while (mac_soft_reset !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		chk("mac reset pulse", 1'b1, mac_soft_reset);
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("tx config after reset", 32'h0, d);
		h.rd32(HW_CONFIG_OFFSET, d);
		chk("hw config after reset", hwf(1'b1, cur, 2'h0), d);
		@(posedge clk);
		wake_event <= 1'b1;
		@(posedge clk);
		wake_event <= 1'b0;
		h.wr32(TX_CONFIG_OFFSET, 32'h00000004);
		h.rd32(TX_CONFIG_OFFSET, d);
		chk("write after wake", 32'h0, d);
		// clock enable low freezes the interrupt copy
		clk_en <= 1'b0;
		tx_status_full <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("irq frozen", 1'b0, status_full_irq);
		clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("irq after enable", 1'b1, status_full_irq);
		complete_run();
	end
endmodule : tx_and_hw_config_regs_bench
